// ==== comparator_digital_control.sv ====
// Digital control, status, edge flag and APB registers of one analog comparator
//
// Function
// (R01) Sync bit set: capture result on each timer source clock falling edge.
// (R02) Sync bit clear: result passes to timer gate and pin unclocked.
// (R03) Rising edge enable set: flag on each low-to-high status transition.
// (R04) Falling edge enable set: flag on each high-to-low status transition.
// (R05) Only software clears the flag; an edge during clearing wins.
// (R06) Disabled comparator still flags edges from polarity or enable toggles.
// (R07) Interrupt forwarded only with enable and all three interrupt enables set.
// (R08) Status bit reads 1 for positive above negative, uninverted.
// (R09) Polarity bit inverts result before status and all outputs.
// (R10) Enable clear powers comparator down and disables all inputs.
// (R11) Software keeps speed/power bit at 1; it resets to 1.
// (R12) Hysteresis bit turns input hysteresis on or off.
// (R13) Positive select: 111 ground, 110 reference, 101 converter, 000 pin.
// (R14) Negative select: 111 ground, 110 reference, 011..000 pins 3..0.
// (R15) Synchronized path stops in sleep when timer uses system clocks.
// (R16) Flag wakes device from sleep when interrupt enable is set.
// (R17) Active output with shutdown enable suspends the waveform unit.
// (R18) Internal output registered once per instruction cycle.
// (R19) Shared mirror register: bit 0 this result, bit 1 second comparator.
// (R20) Edges found by comparing registered status with previous sample.

module comparator_digital_control
    import comparator_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog front end
    input  wire logic        analog_compare,
    output logic             comparator_power_on,
    output logic             hysteresis_on,
    output logic             speed_power_select,
    output logic             pos_ground_sel,
    output logic             pos_fixed_reference_sel,
    output logic             pos_dac_sel,
    output logic             pos_pin0_sel,
    output logic             neg_ground_sel,
    output logic             neg_fixed_reference_sel,
    output logic       [3:0] neg_pin_sel,
    // Timer and system
    input  wire logic        timer_src_clk,
    input  wire logic        timer_clk_is_system,
    input  wire logic        sleep_active,
    input  wire logic        instr_cycle_tick,
    input  wire logic        other_result_bit,
    // Interrupt controller
    input  wire logic        peripheral_irq_enable,
    input  wire logic        global_irq_enable,
    output logic             irq_out,
    output logic             wake_out,
    // Timer gate, pin and waveform unit
    output logic             timer_gate_out,
    output logic             pin_out,
    input  wire logic        shutdown_source_enable,
    output logic             shutdown_out
);

    `include "comparator_map.svh"

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg8_t  control_0_reg;
    reg8_t  control_1_reg;
    logic   comparator_irq_flag_reg;
    logic   comparator_irq_enable_reg;
    logic   result_reg;
    logic   result_prev_reg;
    logic   sync_reg;
    logic   timer_clk_prev_reg;

    logic   wr_en;
    logic   rd_en;
    logic   addr_ok;
    logic   comparator_enable;
    logic   output_invert;
    logic   output_sync_enable;
    logic   rising_edge_irq_enable;
    logic   falling_edge_irq_enable;
    logic   pol_out;
    logic   rise_seen;
    logic   fall_seen;
    logic   edge_set;
    logic   flag_clear;
    logic   timer_fall;
    logic   sync_stopped;
    logic   drive_out;
    input_select_t positive_input_select;
    input_select_t negative_input_select;

    assign comparator_enable       = control_0_reg[`C0_ENABLE_BIT];
    assign output_invert           = control_0_reg[`C0_INVERT_BIT];
    assign output_sync_enable      = control_0_reg[`C0_SYNC_BIT];
    assign rising_edge_irq_enable  = control_1_reg[`C1_RISE_BIT];
    assign falling_edge_irq_enable = control_1_reg[`C1_FALL_BIT];
    assign positive_input_select   = control_1_reg[`C1_POS_MSB:`C1_POS_LSB];
    assign negative_input_select   = control_1_reg[`C1_NEG_MSB:`C1_NEG_LSB];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;

    always_comb begin
        case (paddr)
            `ADDR_CONTROL_0,
            `ADDR_CONTROL_1,
            `ADDR_OUTPUT_MIRROR,
            `ADDR_IRQ_FLAG,
            `ADDR_IRQ_ENABLE: addr_ok = 1'b1;
            default:          addr_ok = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `ADDR_CONTROL_0: begin
                prdata[7:0] = control_0_reg;
                // (R08) status bit view
                prdata[`C0_RESULT_BIT] = result_reg;
            end
            `ADDR_CONTROL_1:     prdata[7:0] = control_1_reg;
            // (R19) shared mirror bits
            `ADDR_OUTPUT_MIRROR: prdata[1:0] = {other_result_bit, result_reg};
            `ADDR_IRQ_FLAG:      prdata[0]   = comparator_irq_flag_reg;
            `ADDR_IRQ_ENABLE:    prdata[0]   = comparator_irq_enable_reg;
            default:             prdata      = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // (R11) speed bit resets high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_0_reg <= `C0_RESET;
        end else if (wr_en && paddr == `ADDR_CONTROL_0) begin
            control_0_reg <= pwdata[7:0] & `C0_WRITE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_1_reg <= `C1_RESET;
        end else if (wr_en && paddr == `ADDR_CONTROL_1) begin
            control_1_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_irq_enable_reg <= 1'b0;
        end else if (wr_en && paddr == `ADDR_IRQ_ENABLE) begin
            comparator_irq_enable_reg <= pwdata[0];
        end
    end

    // ------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------
    // (R10) power and input gating
    assign comparator_power_on = comparator_enable;
    // (R12) hysteresis control
    assign hysteresis_on       = control_0_reg[`C0_HYST_BIT];
    // Reserved value 0 is passed on as written; software must avoid it
    assign speed_power_select  = control_0_reg[`C0_SPEED_BIT];

    // (R13) positive input decode
    assign pos_ground_sel          = comparator_enable && positive_input_select == `SEL_GROUND;
    assign pos_fixed_reference_sel = comparator_enable
                                     && positive_input_select == `SEL_FIXED_REF;
    assign pos_dac_sel             = comparator_enable && positive_input_select == `SEL_DAC;
    assign pos_pin0_sel            = comparator_enable && positive_input_select == `SEL_PIN0;

    // (R14) negative input decode
    assign neg_ground_sel          = comparator_enable && negative_input_select == `SEL_GROUND;
    assign neg_fixed_reference_sel = comparator_enable
                                     && negative_input_select == `SEL_FIXED_REF;
    genvar gi;
    generate
        for (gi = 0; gi < `NEG_PIN_COUNT; gi++) begin : g_neg_pin
            assign neg_pin_sel[gi] = comparator_enable
                                     && negative_input_select == input_select_t'(gi);
        end
    endgenerate

    // ------------------------------------------------------------
    // Output path
    // ------------------------------------------------------------
    // (R09) polarity; disabled core reads low so toggles still make edges
    assign pol_out = (comparator_enable && analog_compare) ^ output_invert;

    // (R18) status sampled per instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 1'b0;
        end else if (instr_cycle_tick) begin
            result_reg <= pol_out;
        end
    end

    // Timer source clock is sampled as a data level, not used as a clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_clk_prev_reg <= 1'b0;
        end else begin
            timer_clk_prev_reg <= timer_src_clk;
        end
    end

    assign timer_fall = timer_clk_prev_reg && !timer_src_clk;
    // (R15) system clocks halt in sleep
    assign sync_stopped = sleep_active && timer_clk_is_system;

    // (R01) capture on falling timer clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg <= 1'b0;
        end else if (timer_fall && !sync_stopped) begin
            sync_reg <= pol_out;
        end
    end

    // (R02) unclocked path when sync is off
    assign drive_out      = output_sync_enable ? sync_reg : pol_out;
    assign timer_gate_out = drive_out;
    assign pin_out        = drive_out;
    // (R17) immediate shutdown request
    assign shutdown_out   = drive_out && shutdown_source_enable;

    // ------------------------------------------------------------
    // Edge detection and flag
    // ------------------------------------------------------------
    // (R20) compare with previous sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_prev_reg <= 1'b0;
        end else begin
            result_prev_reg <= result_reg;
        end
    end

    // (R03) rising edge
    assign rise_seen  = result_reg && !result_prev_reg;
    // (R04) falling edge
    assign fall_seen  = !result_reg && result_prev_reg;
    // (R06) no enable gating on edges
    assign edge_set   = (rise_seen && rising_edge_irq_enable)
                        || (fall_seen && falling_edge_irq_enable);
    assign flag_clear = wr_en && paddr == `ADDR_IRQ_FLAG && pwdata[0];

    // (R05) set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_irq_flag_reg <= 1'b0;
        end else if (edge_set) begin
            comparator_irq_flag_reg <= 1'b1;
        end else if (flag_clear) begin
            comparator_irq_flag_reg <= 1'b0;
        end
    end

    // (R07) interrupt gating
    assign irq_out  = comparator_irq_flag_reg && comparator_enable
                      && comparator_irq_enable_reg && peripheral_irq_enable
                      && global_irq_enable;
    // (R16) wake request
    assign wake_out = comparator_irq_flag_reg && comparator_irq_enable_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_sync_capture;
        @(posedge pclk) disable iff (!presetn)
        (timer_fall && !sync_stopped) |=> (sync_reg == $past(pol_out));
    endproperty
    a_sync_capture: assert property (p_sync_capture) // (R01)
        else $error("sync capture missed falling edge");
    property p_async_path;
        @(posedge pclk) disable iff (!presetn)
        !output_sync_enable |-> (pin_out == pol_out && timer_gate_out == pol_out);
    endproperty
    a_async_path: assert property (p_async_path) // (R02)
        else $error("async output path differs from result");
    property p_rise_flag;
        @(posedge pclk) disable iff (!presetn)
        (rising_edge_irq_enable && result_reg && !result_prev_reg) |=> comparator_irq_flag_reg;
    endproperty
    a_rise_flag: assert property (p_rise_flag) // (R03)
        else $error("rising edge did not set flag");
    property p_fall_flag;
        @(posedge pclk) disable iff (!presetn)
        (falling_edge_irq_enable && !result_reg && result_prev_reg) |=> comparator_irq_flag_reg;
    endproperty
    a_fall_flag: assert property (p_fall_flag) // (R04)
        else $error("falling edge did not set flag");
    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        (comparator_irq_flag_reg && !flag_clear) |=> comparator_irq_flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // (R05)
        else $error("flag dropped without software clear");
    property p_no_edge_no_flag;
        @(posedge pclk) disable iff (!presetn)
        (!comparator_irq_flag_reg && !edge_set) |=> !comparator_irq_flag_reg;
    endproperty
    a_no_edge_no_flag: assert property (p_no_edge_no_flag) // (R03)
        else $error("flag set without an enabled edge");
    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        irq_out |-> (comparator_irq_flag_reg && comparator_enable && comparator_irq_enable_reg
                     && peripheral_irq_enable && global_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) // (R07)
        else $error("interrupt forwarded while gated");
    property p_status_polarity;
        @(posedge pclk) disable iff (!presetn)
        instr_cycle_tick |=> (result_reg == ($past(comparator_enable && analog_compare)
                                             ^ $past(output_invert)));
    endproperty
    a_status_polarity: assert property (p_status_polarity) // (R09)
        else $error("status bit polarity wrong");
    property p_sleep_hold;
        @(posedge pclk) disable iff (!presetn)
        sync_stopped |=> $stable(sync_reg);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) // (R15)
        else $error("sync path moved while stopped");
    property p_shutdown;
        @(posedge pclk) disable iff (!presetn)
        (shutdown_source_enable && drive_out) |-> shutdown_out;
    endproperty
    a_shutdown: assert property (p_shutdown) // (R17)
        else $error("shutdown not requested");

    property p_inputs_off;
        @(posedge pclk) disable iff (!presetn)
        !comparator_enable |-> (!pos_pin0_sel && neg_pin_sel == 4'h0 && !pos_dac_sel);
    endproperty
    a_inputs_off: assert property (p_inputs_off) // (R10)
        else $error("input selected while disabled");

    cover property (@(posedge pclk) disable iff (!presetn) edge_set && flag_clear);
    cover property (@(posedge pclk) disable iff (!presetn) irq_out);
    cover property (@(posedge pclk) disable iff (!presetn)
                    output_sync_enable && timer_fall ##1 pin_out);
    cover property (@(posedge pclk) disable iff (!presetn)
                    !comparator_enable && $changed(output_invert) ##[1:40] edge_set);

endmodule

// ==== comparator_map.svh ====
// Register offsets, field positions, reset values and codes of the comparator control block
`ifndef COMPARATOR_MAP_SVH
`define COMPARATOR_MAP_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL_0      12'h000
`define ADDR_CONTROL_1      12'h004
`define ADDR_OUTPUT_MIRROR  12'h008
`define ADDR_IRQ_FLAG       12'h00c
`define ADDR_IRQ_ENABLE     12'h010
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define C0_ENABLE_BIT       7
`define C0_RESULT_BIT       6
`define C0_INVERT_BIT       4
`define C0_SPEED_BIT        2
`define C0_HYST_BIT         1
`define C0_SYNC_BIT         0
`define C0_WRITE_MASK       8'h97
`define C0_RESET            8'h04
`define C1_RISE_BIT         7
`define C1_FALL_BIT         6
`define C1_POS_MSB          5
`define C1_POS_LSB          3
`define C1_NEG_MSB          2
`define C1_NEG_LSB          0
`define C1_RESET            8'h00
// ----------------------------------------------------------------
// Input select codes
// ----------------------------------------------------------------
`define SEL_GROUND          3'h7
`define SEL_FIXED_REF       3'h6
`define SEL_DAC             3'h5
`define SEL_PIN0            3'h0
`define NEG_PIN_COUNT       4
`endif

// ==== comparator_pkg.sv ====
// Types shared by the comparator control block
package comparator_pkg;
    `include "comparator_map.svh"
    typedef logic [7:0] reg8_t;
    typedef logic [2:0] input_select_t;
endpackage

// ==== comparator_far_side_model.sv ====
// Timer and instruction clock model standing at the far side of the comparator block
module comparator_far_side_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control from the bench
    input  wire logic timer_run,
    // Timer and system
    output logic      instr_cycle_tick,
    output logic      timer_src_clk
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] tick_count_reg;

    // ----------------------------------------------------------------
    // Instruction cycle of four system clocks
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count_reg   <= 2'h0;
            instr_cycle_tick <= 1'b0;
        end else begin
            tick_count_reg   <= tick_count_reg + 2'h1;
            instr_cycle_tick <= (tick_count_reg == 2'h3);
        end
    end

    // ----------------------------------------------------------------
    // Timer source clock
    // ----------------------------------------------------------------
    // Stands still while stopped, so a held sync output can be seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_src_clk <= 1'b0;
        end else if (timer_run && tick_count_reg[0]) begin
            timer_src_clk <= ~timer_src_clk;
        end
    end
endmodule

// ==== comparator_digital_control_tb_top.sv ====
// Self-checking bench of the comparator control block
`include "comparator_map.svh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module comparator_digital_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import comparator_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic        pready, pslverr, rd_err;
    logic        analog_compare, timer_run, timer_src_clk, timer_clk_is_system;
    logic        sleep_active, instr_cycle_tick, other_result_bit;
    logic        peripheral_irq_enable, global_irq_enable, shutdown_source_enable;
    logic        power_on, hyst_on, speed_sel, irq_out, wake_out, gate_out, pin_out, shut_out;
    logic        p_gnd, p_ref, p_dac, p_pin0, n_gnd, n_ref;
    logic [3:0]  n_pin;
    int          miscompares, samples_checked;

    comparator_digital_control uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analog_compare(analog_compare), .comparator_power_on(power_on),
        .hysteresis_on(hyst_on), .speed_power_select(speed_sel),
        .pos_ground_sel(p_gnd), .pos_fixed_reference_sel(p_ref), .pos_dac_sel(p_dac),
        .pos_pin0_sel(p_pin0), .neg_ground_sel(n_gnd), .neg_fixed_reference_sel(n_ref),
        .neg_pin_sel(n_pin), .timer_src_clk(timer_src_clk),
        .timer_clk_is_system(timer_clk_is_system), .sleep_active(sleep_active),
        .instr_cycle_tick(instr_cycle_tick), .other_result_bit(other_result_bit),
        .peripheral_irq_enable(peripheral_irq_enable), .global_irq_enable(global_irq_enable),
        .irq_out(irq_out), .wake_out(wake_out), .timer_gate_out(gate_out), .pin_out(pin_out),
        .shutdown_source_enable(shutdown_source_enable), .shutdown_out(shut_out));

    comparator_far_side_model far_side (
        .pclk(pclk), .presetn(presetn), .timer_run(timer_run),
        .instr_cycle_tick(instr_cycle_tick), .timer_src_clk(timer_src_clk));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h00000000);
        `CHECK(rd_data, {24'h000000, exp})
    endtask

    // Three instruction cycles, long enough to cover the edge stage
    task automatic settle();
        repeat (12) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic finish_test();
        $display("checked %0d values, %0d mismatches", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, reset and watchdog
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h00000000; analog_compare = 1'b0;
        timer_run = 1'b1; timer_clk_is_system = 1'b0; sleep_active = 1'b0;
        other_result_bit = 1'b0; peripheral_irq_enable = 1'b0;
        global_irq_enable = 1'b0; shutdown_source_enable = 1'b0;
        miscompares = 0; samples_checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Speed bit resets to 1
        rd_chk(`ADDR_CONTROL_0, 8'h04);
        rd_chk(`ADDR_CONTROL_1, 8'h00);
        rd_chk(`ADDR_OUTPUT_MIRROR, 8'h00);
        apb(1'b0, 12'h014, 32'h00000000);
        `CHECK(rd_err, 1'b1)
        done("reset");
        // Input decode for every code, enabled
        wr(`ADDR_CONTROL_0, 8'h84);
        for (int i = 0; i < 8; i++) begin
            wr(`ADDR_CONTROL_1, {2'b00, i[2:0], i[2:0]});
            @(negedge pclk);
            // Decode of both selects
            `CHECK({p_gnd, p_ref, p_dac, p_pin0}, {i == 7, i == 6, i == 5, i == 0})
            `CHECK({n_gnd, n_ref, n_pin}, {i == 7, i == 6, (i < 4) ? 4'h1 << i : 4'h0})
        end
        // Disabled comparator powers down and drops every negative input
        wr(`ADDR_CONTROL_0, 8'h06);
        @(negedge pclk);
        `CHECK({power_on, n_gnd, n_ref, n_pin}, 7'h00)
        `CHECK({hyst_on, speed_sel}, 2'b11)
        done("decode");
        // Rising edge only
        wr(`ADDR_CONTROL_1, 8'h80);
        wr(`ADDR_CONTROL_0, 8'h84);
        settle();
        wr(`ADDR_IRQ_FLAG, 8'h01);
        rd_chk(`ADDR_IRQ_FLAG, 8'h00);
        analog_compare <= 1'b1;
        settle();
        rd_chk(`ADDR_IRQ_FLAG, 8'h01);
        rd_chk(`ADDR_CONTROL_0, 8'hc4);
        rd_chk(`ADDR_OUTPUT_MIRROR, 8'h01);
        wr(`ADDR_IRQ_FLAG, 8'h01);
        rd_chk(`ADDR_IRQ_FLAG, 8'h00);
        other_result_bit <= 1'b1;
        analog_compare <= 1'b0;
        settle();
        rd_chk(`ADDR_IRQ_FLAG, 8'h00);
        rd_chk(`ADDR_OUTPUT_MIRROR, 8'h02);
        // Falling edge only
        wr(`ADDR_CONTROL_1, 8'h40);
        analog_compare <= 1'b1;
        settle();
        rd_chk(`ADDR_IRQ_FLAG, 8'h00);
        analog_compare <= 1'b0;
        settle();
        rd_chk(`ADDR_IRQ_FLAG, 8'h01);
        done("edges");
        // Polarity toggle while disabled
        wr(`ADDR_CONTROL_1, 8'hc0);
        wr(`ADDR_CONTROL_0, 8'h04);
        settle();
        wr(`ADDR_IRQ_FLAG, 8'h01);
        rd_chk(`ADDR_IRQ_FLAG, 8'h00);
        wr(`ADDR_CONTROL_0, 8'h14);
        settle();
        rd_chk(`ADDR_IRQ_FLAG, 8'h01);
        rd_chk(`ADDR_CONTROL_0, 8'h54);
        done("disabled");
        // Interrupt gating, flag held set; status stays 1 throughout
        for (int i = 0; i < 16; i++) begin
            wr(`ADDR_CONTROL_0, i[3] ? 8'h94 : 8'h14);
            wr(`ADDR_IRQ_ENABLE, {7'h00, i[2]});
            @(posedge pclk);
            peripheral_irq_enable <= i[1];
            global_irq_enable     <= i[0];
            @(negedge pclk);
            `CHECK(irq_out, &i[3:0])
            `CHECK(wake_out, i[2])
        end
        done("gating");
        // Unclocked output path
        wr(`ADDR_CONTROL_0, 8'h84);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            analog_compare <= i[0];
            shutdown_source_enable <= i[1];
            @(negedge pclk);
            `CHECK({gate_out, pin_out}, {2{i[0]}})
            `CHECK(shut_out, i[0] & i[1])
        end
        done("async");
        // Synchronized output path
        wr(`ADDR_CONTROL_0, 8'h85);
        settle();
        `CHECK(pin_out, 1'b1)
        @(posedge pclk);
        timer_run <= 1'b0;
        // A fall already seen may still capture once after the stop
        repeat (2) @(posedge pclk);
        analog_compare <= 1'b0;
        settle();
        `CHECK({gate_out, pin_out}, 2'b11)
        @(posedge pclk);
        timer_run <= 1'b1;
        settle();
        `CHECK({gate_out, pin_out}, 2'b00)
        @(posedge pclk);
        sleep_active <= 1'b1;
        timer_clk_is_system <= 1'b1;
        analog_compare <= 1'b1;
        settle();
        `CHECK(pin_out, 1'b0)
        @(posedge pclk);
        timer_clk_is_system <= 1'b0;
        settle();
        `CHECK(pin_out, 1'b1)
        done("sync");
        finish_test();
    end
endmodule
